// ==== rtl/ascx_params.svh ====
/*
  Constants of the converter status and control block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 100 MHz sys_clk and a 32-bit AXI4-Lite register bus.
*/
`ifndef ASCX_PARAMS_SVH
`define ASCX_PARAMS_SVH

// =====================================================================
// Register byte offsets
`define ASCX_OFF_SC1 8'h00
`define ASCX_OFF_SC2 8'h04
`define ASCX_OFF_IRQ_STATUS 8'h08
`define ASCX_OFF_IRQ_MASK 8'h0C

// =====================================================================
// Status and control one fields
`define ASCX_SC1_DONE_FLAG 7
`define ASCX_SC1_IRQ_EN 6
`define ASCX_SC1_CONT 5
`define ASCX_SC1_CH_HI 4
`define ASCX_SC1_CH_LO 0
`define ASCX_CH_OFF 5'h1F
`define ASCX_CH_RESERVED 5'h1C
`define ASCX_CH_REF_HIGH 5'h1D
`define ASCX_CH_REF_LOW 5'h1E
`define ASCX_CH_LAST_INPUT 5'h1B

// =====================================================================
// Status and control two fields
`define ASCX_SC2_ACTIVE 7
`define ASCX_SC2_TRIG_SEL 6
`define ASCX_SC2_CMP_EN 5

// =====================================================================
// Interrupt status and mask bits
`define ASCX_IRQ_COMPLETE 0
`define ASCX_IRQ_HW_TRIG 1
`define ASCX_IRQ_BITS 2

// =====================================================================
// Reset values
`define ASCX_SC1_RESET 8'h1F
`define ASCX_SC2_RESET 8'h00
`define ASCX_MASK_RESET 2'h0

// =====================================================================
// Timing
`define ASCX_CLK_MHZ 100
`define ASCX_CONV_TIME_NS 2000
`define ASCX_CONV_CYCLES ((`ASCX_CONV_TIME_NS * `ASCX_CLK_MHZ) / 1000)

// =====================================================================
// AXI responses
`define ASCX_RESP_OKAY 2'h0
`define ASCX_RESP_DECERR 2'h3

`endif

// ==== rtl/ascx_pkg.sv ====
/*
  Types of the converter status and control block.
  Assumes ascx_params.svh holds all numeric constants.
*/
package ascx_pkg;

  // =====================================================================
  // Conversion sequencer states
  typedef enum logic {
    ASCX_IDLE,
    ASCX_RUN
  } ascx_seq_state_type;

endpackage : ascx_pkg

// ==== rtl/ascx_conv_seq.sv ====
/*
  Conversion sequencer: times one conversion, repeats in continuous mode,
  and returns the converter to idle after a single conversion.
  Assumes start and abort are one-cycle pulses from the register logic.
*/
`timescale 1ns/100ps
`include "ascx_params.svh"

module ascx_conv_seq
  import ascx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic start,
  input wire logic abort,
  input wire logic cont_mode,
  output logic busy,
  output logic done,
  output logic start_out
);

  localparam int CONV_CYCLES = `ASCX_CONV_CYCLES;

  ascx_seq_state_type state_q, state_d;
  logic [15:0] count_q, count_d;
  logic done_q, done_d;
  logic start_q, start_d;

  // =====================================================================
  // Next state
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    done_d = 1'b0;
    start_d = 1'b0;
    case (state_q)
      ASCX_IDLE: begin
        if (start) begin
          state_d = ASCX_RUN;
          count_d = 16'h0000;
          start_d = 1'b1;
        end
      end
      ASCX_RUN: begin
        if (abort) begin
          state_d = ASCX_IDLE;
          if (start) begin
            state_d = ASCX_RUN;
            count_d = 16'h0000;
            start_d = 1'b1;
          end
        end else if (count_q == 16'(CONV_CYCLES - 1)) begin
          done_d = 1'b1;
          count_d = 16'h0000;
          if (cont_mode) begin
            start_d = 1'b1;
          end else begin
            state_d = ASCX_IDLE;
          end
        end else begin
          count_d = count_q + 16'h0001;
        end
      end
      default: begin
        state_d = ASCX_IDLE;
      end
    endcase
  end

  // =====================================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= ASCX_IDLE;
      count_q <= 16'h0000;
      done_q <= 1'b0;
      start_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      count_q <= count_d;
      done_q <= done_d;
      start_q <= start_d;
    end
  end

  assign busy = (state_q == ASCX_RUN);
  assign done = done_q;
  assign start_out = start_q;

endmodule : ascx_conv_seq

// ==== rtl/ascx_status_control.sv ====
/*
  Primary status and control logic of a 10-bit converter with an
  AXI4-Lite register slave, conversion start and abort, complete flag,
  channel select and interrupt.
  Assumes the analog core reports the compare outcome on compare_true
  during the cycle done is high, and the result block pulses
  result_low_read when software reads the low result.
*/
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "ascx_params.svh"

module ascx_status_control
  import ascx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hardware_trigger_input,
  input wire logic compare_true,
  input wire logic result_low_read,
  output logic conv_start,
  output logic conv_active,
  output logic converter_enable,
  output logic input_isolate,
  output logic [4:0] input_channel_select,
  output logic irq
);

  // =====================================================================
  // Bus state
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic wr_fire;
  logic wr_known;

  // =====================================================================
  // Register state
  logic cflag_q, cflag_d;
  logic ien_q, ien_d;
  logic cont_q, cont_d;
  logic [4:0] chan_q, chan_d;
  logic trig_sel_q, trig_sel_d;
  logic cmp_en_q, cmp_en_d;
  logic [`ASCX_IRQ_BITS-1:0] sts_q, sts_d;
  logic [`ASCX_IRQ_BITS-1:0] mask_q, mask_d;

  // =====================================================================
  // Sequencer links
  logic sc1_write;
  logic new_chan_off;
  logic sw_start;
  logic hw_start;
  logic seq_start;
  logic seq_abort;
  logic seq_cont;
  logic seq_busy;
  logic seq_done;
  logic seq_start_out;
  logic cflag_set;

  // =====================================================================
  // Reset image of status and control one
  localparam logic [7:0] SC1_RESET = `ASCX_SC1_RESET;

  // =====================================================================
  // Write decode
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_known = (awaddr_q == `ASCX_OFF_SC1) || (awaddr_q == `ASCX_OFF_SC2) ||
                    (awaddr_q == `ASCX_OFF_IRQ_STATUS) || (awaddr_q == `ASCX_OFF_IRQ_MASK);
  assign sc1_write = wr_fire && (awaddr_q == `ASCX_OFF_SC1) && wstrb0_q;

  // =====================================================================
  // AXI4-Lite write and read channels
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_known ? `ASCX_RESP_OKAY : `ASCX_RESP_DECERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = `ASCX_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      case ({s_axi_araddr[7:2], 2'b00})
        `ASCX_OFF_SC1: begin
          rdata_d[7:0] = {cflag_q, ien_q, cont_q, chan_q};
        end
        `ASCX_OFF_SC2: begin
          rdata_d[`ASCX_SC2_ACTIVE] = seq_busy;
          rdata_d[`ASCX_SC2_TRIG_SEL] = trig_sel_q;
          rdata_d[`ASCX_SC2_CMP_EN] = cmp_en_q;
        end
        `ASCX_OFF_IRQ_STATUS: begin
          rdata_d[`ASCX_IRQ_BITS-1:0] = sts_q;
        end
        `ASCX_OFF_IRQ_MASK: begin
          rdata_d[`ASCX_IRQ_BITS-1:0] = mask_q;
        end
        default: begin
          rresp_d = `ASCX_RESP_DECERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `ASCX_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ASCX_RESP_OKAY;
    end else if (clk_en) begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_awready = clk_en && !aw_held_q && !bvalid_q;
  assign s_axi_wready = clk_en && !w_held_q && !bvalid_q;
  assign s_axi_arready = clk_en && !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // =====================================================================
  // Start and abort decisions
  assign new_chan_off = (wdata_q[`ASCX_SC1_CH_HI:`ASCX_SC1_CH_LO] == `ASCX_CH_OFF);
  assign sw_start = sc1_write && !trig_sel_q && !new_chan_off;
  // With trig_sel_q set, each overflow pulse starts one conversion when idle, with the channel not off and no status and control one write in that cycle
  assign hw_start = trig_sel_q && hardware_trigger_input && !seq_busy &&
                    !sc1_write && (chan_q != `ASCX_CH_OFF);
  assign seq_start = sw_start || hw_start;
  assign seq_abort = sc1_write;
  assign seq_cont = cont_q && (chan_q != `ASCX_CH_OFF);

  ascx_conv_seq u_conv_seq (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(seq_start),
    .abort(seq_abort),
    .cont_mode(seq_cont),
    .busy(seq_busy),
    .done(seq_done),
    .start_out(seq_start_out)
  );

  assign cflag_set = seq_done && (!cmp_en_q || compare_true);

  // =====================================================================
  // Control registers and complete flag
  always_comb begin
    cflag_d = cflag_q;
    ien_d = ien_q;
    cont_d = cont_q;
    chan_d = chan_q;
    trig_sel_d = trig_sel_q;
    cmp_en_d = cmp_en_q;
    sts_d = sts_q;
    mask_d = mask_q;
    if (sc1_write || result_low_read) begin
      cflag_d = 1'b0;
    end
    if (cflag_set) begin
      cflag_d = 1'b1;
    end
    if (sc1_write) begin
      ien_d = wdata_q[`ASCX_SC1_IRQ_EN];
      cont_d = wdata_q[`ASCX_SC1_CONT];
      chan_d = wdata_q[`ASCX_SC1_CH_HI:`ASCX_SC1_CH_LO];
    end
    if (wr_fire && wstrb0_q && (awaddr_q == `ASCX_OFF_SC2)) begin
      trig_sel_d = wdata_q[`ASCX_SC2_TRIG_SEL];
      cmp_en_d = wdata_q[`ASCX_SC2_CMP_EN];
    end
    if (wr_fire && wstrb0_q && (awaddr_q == `ASCX_OFF_IRQ_MASK)) begin
      mask_d = wdata_q[`ASCX_IRQ_BITS-1:0];
    end
    if (wr_fire && wstrb0_q && (awaddr_q == `ASCX_OFF_IRQ_STATUS)) begin
      sts_d = sts_q & ~wdata_q[`ASCX_IRQ_BITS-1:0];
    end
    // Set wins over a same-cycle clear
    if (cflag_set && ien_q) begin
      sts_d[`ASCX_IRQ_COMPLETE] = 1'b1;
    end
    if (hw_start) begin
      sts_d[`ASCX_IRQ_HW_TRIG] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cflag_q <= SC1_RESET[`ASCX_SC1_DONE_FLAG];
      ien_q <= SC1_RESET[`ASCX_SC1_IRQ_EN];
      cont_q <= SC1_RESET[`ASCX_SC1_CONT];
      chan_q <= SC1_RESET[`ASCX_SC1_CH_HI:`ASCX_SC1_CH_LO];
      trig_sel_q <= 1'b0;
      cmp_en_q <= 1'b0;
      sts_q <= '0;
      mask_q <= `ASCX_MASK_RESET;
    end else if (clk_en) begin
      cflag_q <= cflag_d;
      ien_q <= ien_d;
      cont_q <= cont_d;
      chan_q <= chan_d;
      trig_sel_q <= trig_sel_d;
      cmp_en_q <= cmp_en_d;
      sts_q <= sts_d;
      mask_q <= mask_d;
    end
  end

  // =====================================================================
  // Outputs to the analog core and the interrupt line
  assign conv_start = seq_start_out;
  assign conv_active = seq_busy;
  assign converter_enable = seq_busy && (chan_q != `ASCX_CH_OFF);
  assign input_isolate = (chan_q == `ASCX_CH_OFF);
  assign input_channel_select = chan_q;
  assign irq = |(sts_q & mask_q);

endmodule : ascx_status_control

// ==== tb/ascx_sc_props.sv ====
/*
  Port checker of the converter status and control block.
  Assumes it is bound onto ascx_status_control and sees only its ports.
*/
`timescale 1ns/100ps
`include "ascx_params.svh"

module ascx_sc_props (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_start,
  input wire logic conv_active,
  input wire logic converter_enable,
  input wire logic input_isolate,
  input wire logic [4:0] input_channel_select
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // =====================================================================
  // Length of the running conversion
  int run_q;
  int run_d;
  always_comb run_d = conv_start ? 0 : (conv_active ? run_q + int'(clk_en) : 0);
  always_ff @(posedge sys_clk) run_q <= sys_rst ? 0 : run_d;

  sequence b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  // =====================================================================
  // Properties
  chk_isolate_off: assert property (input_isolate == (input_channel_select == `ASCX_CH_OFF))
    else $error("isolate does not follow channel code");
  chk_enable_off: assert property (converter_enable == (conv_active && !input_isolate))
    else $error("converter enable wrong");
  chk_start_rise: assert property ($rose(conv_active) |-> conv_start)
    else $error("conversion began without start pulse");
  chk_start_pulse: assert property (conv_start && clk_en |=> !conv_start)
    else $error("start pulse longer than one cycle");
  chk_run_bound: assert property (run_q <= `ASCX_CONV_CYCLES + 2)
    else $error("conversion runs too long");
  chk_channel_write: assert property ($changed(input_channel_select) |-> $rose(s_axi_bvalid))
    else $error("channel changed without a write");
  chk_bresp_hold: assert property (b_wait |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_rdata_hold: assert property (r_wait |=> s_axi_rvalid)
    else $error("read data dropped early");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
endmodule : ascx_sc_props

bind ascx_status_control ascx_sc_props chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .conv_start(conv_start),
  .conv_active(conv_active), .converter_enable(converter_enable), .input_isolate(input_isolate),
  .input_channel_select(input_channel_select));

// ==== tb/ascx_status_control_tb.sv ====
/*
  Self-checking bench of the converter status and control block.
  Assumes the 200-cycle conversion and the register map of the hand-over.
*/
`timescale 1ns/100ps
`include "ascx_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module ascx_status_control_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic hardware_trigger_input = 1'b0, compare_true = 1'b0, result_low_read = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic conv_start, conv_active, converter_enable, input_isolate, irq;
  logic [4:0] input_channel_select;
  int fail_count = 0;
  int checks = 0;
  int starts = 0;
  int m_sc1, ch, base;

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (conv_start === 1'b1) starts <= starts + 1;

  ascx_status_control dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .hardware_trigger_input(hardware_trigger_input), .compare_true(compare_true),
    .result_low_read(result_low_read), .conv_start(conv_start), .conv_active(conv_active),
    .converter_enable(converter_enable), .input_isolate(input_isolate),
    .input_channel_select(input_channel_select), .irq(irq));

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc

  // =====================================================================
  // Register bus master
  task automatic wr(input logic [7:0] a, input int d, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask : wr

  task automatic rd(input logic [7:0] a, input int ed, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK("rresp", er, s_axi_rresp)
    `CHK("rdata", ed[31:0], s_axi_rdata)
  endtask : rd

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  initial begin
    #(20000 * 10);
    fail_count++;
    end_sim();
  end

  // =====================================================================
  // Main sequence
  initial begin
    void'($urandom(32680));
    cyc(8);
    sys_rst <= 1'b0;
    cyc(1);
    `CHK("isolate", 1'b1, input_isolate);
    rd(`ASCX_OFF_SC1, 'h1F, `ASCX_RESP_OKAY);
    for (int c = 0; c < 32; c++) begin
      m_sc1 = c | (($urandom % 2) << 6);
      wr(`ASCX_OFF_SC1, m_sc1, `ASCX_RESP_OKAY);
      rd(`ASCX_OFF_SC1, m_sc1, `ASCX_RESP_OKAY);
      `CHK("channel", c[4:0], input_channel_select);
      `CHK("isolate", c == 31, input_isolate);
    end
    $display("test channel codes done");
    ch = $urandom % 28;
    wr(`ASCX_OFF_IRQ_MASK, 1, `ASCX_RESP_OKAY);
    m_sc1 = 'h40 | ch;
    base = starts;
    wr(`ASCX_OFF_SC1, m_sc1, `ASCX_RESP_OKAY);
    cyc(100);
    wr(`ASCX_OFF_SC1, m_sc1, `ASCX_RESP_OKAY);
    cyc(150);
    `CHK("restarted", 1'b1, conv_active);
    `CHK("irq early", 1'b0, irq);
    cyc(60);
    m_sc1 = m_sc1 | 'h80;
    rd(`ASCX_OFF_SC1, m_sc1, `ASCX_RESP_OKAY);
    `CHK("idle", 1'b0, conv_active);
    `CHK("irq", 1'b1, irq);
    `CHK("starts", 2, starts - base);
    result_low_read <= 1'b1;
    cyc(1);
    result_low_read <= 1'b0;
    m_sc1 = m_sc1 & 'h7F;
    rd(`ASCX_OFF_SC1, m_sc1, `ASCX_RESP_OKAY);
    wr(`ASCX_OFF_IRQ_STATUS, 1, `ASCX_RESP_OKAY);
    `CHK("irq clear", 1'b0, irq);
    $display("test single done");
    m_sc1 = 'h20 | ch;
    base = starts;
    wr(`ASCX_OFF_SC1, m_sc1, `ASCX_RESP_OKAY);
    cyc(420);
    `CHK("cont starts", 3, starts - base);
    rd(`ASCX_OFF_SC1, m_sc1 | 'h80, `ASCX_RESP_OKAY);
    wr(`ASCX_OFF_SC1, 'h3F, `ASCX_RESP_OKAY);
    base = starts;
    cyc(450);
    `CHK("no more", 0, starts - base);
    `CHK("stopped", 1'b0, conv_active);
    rd(`ASCX_OFF_SC1, 'h3F, `ASCX_RESP_OKAY);
    $display("test continuous done");
    wr(`ASCX_OFF_SC2, 'h20, `ASCX_RESP_OKAY);
    wr(`ASCX_OFF_SC1, ch, `ASCX_RESP_OKAY);
    cyc(210);
    rd(`ASCX_OFF_SC1, ch, `ASCX_RESP_OKAY);
    compare_true <= 1'b1;
    wr(`ASCX_OFF_SC1, ch, `ASCX_RESP_OKAY);
    cyc(210);
    rd(`ASCX_OFF_SC1, 'h80 | ch, `ASCX_RESP_OKAY);
    $display("test compare done");
    wr(`ASCX_OFF_SC2, 'h40, `ASCX_RESP_OKAY);
    base = starts;
    wr(`ASCX_OFF_SC1, 'h01, `ASCX_RESP_OKAY);
    cyc(20);
    `CHK("no sw start", 0, starts - base);
    hardware_trigger_input <= 1'b1;
    cyc(1);
    hardware_trigger_input <= 1'b0;
    cyc(3);
    `CHK("hw active", 1'b1, conv_active);
    clk_en <= 1'b0;
    cyc(100);
    clk_en <= 1'b1;
    cyc(150);
    `CHK("frozen run", 1'b1, conv_active);
    cyc(60);
    `CHK("hw starts", 1, starts - base);
    rd(`ASCX_OFF_SC1, 'h81, `ASCX_RESP_OKAY);
    rd(`ASCX_OFF_IRQ_STATUS, 'h2, `ASCX_RESP_OKAY);
    `CHK("irq off", 1'b0, irq);
    $display("test hardware trigger done");
    rd(8'h10, 0, `ASCX_RESP_DECERR);
    wr(8'h14, 'h55, `ASCX_RESP_DECERR);
    $display("test unmapped done");
    end_sim();
  end
endmodule : ascx_status_control_tb
